//--- common/dsmp_pkg.sv
// shared constants, field layout and state type of the dual serial master port
package dsmp_pkg;

   // structure
   localparam int unsigned NPORT = 2;                    // two identical ports
   localparam int unsigned WMAX  = 16;                   // longest word in bits

   // register map, byte addresses
   localparam logic [7:0] PORT_STRIDE = 8'h20;           // distance between port blocks
   localparam logic [7:0] OFF_CTRL    = 8'h00;           // enable, mode, wiring, length, direction
   localparam logic [7:0] OFF_DIV     = 8'h04;           // half bit period in mclk cycles
   localparam logic [7:0] OFF_TX      = 8'h08;           // transmit word, write starts a transfer
   localparam logic [7:0] OFF_RX      = 8'h0C;           // received word, read clears done
   localparam logic [7:0] OFF_STAT    = 8'h10;           // busy and done
   localparam logic [7:0] OFF_SEL     = 8'h40;           // general pins used as peripheral selects

   // control field positions
   localparam int unsigned CTRL_EN_BIT   = 0;            // port owns its pins
   localparam int unsigned CTRL_MODE_LSB = 1;            // bit 1 phase, bit 2 polarity
   localparam int unsigned CTRL_WIRE_LSB = 3;            // wiring code, two bits
   localparam int unsigned CTRL_LEN_LSB  = 5;            // word length minus one, four bits
   localparam int unsigned CTRL_RD_BIT   = 9;            // 3-wire read transfer
   localparam int unsigned CTRL_MSB      = 9;            // highest implemented control bit

   // status field positions
   localparam int unsigned STAT_BUSY_BIT = 0;
   localparam int unsigned STAT_DONE_BIT = 1;

   // wiring codes
   localparam logic [1:0] WIRE_3 = 2'h0;                 // clock, bidirectional data, select
   localparam logic [1:0] WIRE_4 = 2'h1;                 // plus dedicated input
   localparam logic [1:0] WIRE_5 = 2'h2;                 // plus load strobe

   // bit rate limits
   localparam int unsigned CLK_KHZ       = 100000;       // mclk rate
   localparam int unsigned RATE_MAX_KBPS = 13000;        // fastest bit rate
   localparam int unsigned RATE_MIN_KBPS = 102;          // slowest bit rate
   // shortest half period rounds up, longest rounds down
   localparam logic [9:0] HALF_MIN = 10'((CLK_KHZ + 2 * RATE_MAX_KBPS - 1) / (2 * RATE_MAX_KBPS));
   localparam logic [9:0] HALF_MAX = 10'(CLK_KHZ / (2 * RATE_MIN_KBPS));

   // reset values
   localparam logic [CTRL_MSB:0] CTRL_RST = 10'h000;     // port disabled, pins released
   localparam logic [9:0]        DIV_RST  = HALF_MAX;    // slowest rate
   localparam logic [NPORT-1:0]  SEL_RST  = 2'h3;        // selects inactive high
   localparam logic [31:0]       DATA_RST = 32'h0000_0000;

   // shift engine states
   typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_STROBE} dsmp_state_e;

endpackage

//--- hdl/dsmp_shift_engine.sv
// one serial master port: clock generator, shifter, pin drivers and load strobe
//
// Local design decisions: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module dsmp_shift_engine
   import dsmp_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic        cfg_en,
   input  wire logic [1:0]  cfg_mode,
   input  wire logic [1:0]  cfg_wires,
   input  wire logic [3:0]  cfg_len_m1,
   input  wire logic        cfg_rd,
   input  wire logic [9:0]  cfg_half,
   input  wire logic        start,
   input  wire logic [15:0] tx_word,
   output logic             busy,
   output logic             done,
   output logic [15:0]      rx_word,
   output logic             clk_o,
   output logic             clk_oe,
   input  wire logic        dat_i,
   output logic             dat_o,
   output logic             dat_oe,
   input  wire logic        din_i,
   output logic             load_o,
   output logic             load_oe
);

   dsmp_state_e st, next_st;                        // sequence state
   logic [9:0]  hcnt, next_hcnt;                    // cycles into this half period
   logic [4:0]  ecnt, next_ecnt;                    // clock edges so far
   logic [15:0] sh, next_sh;                        // transmit shifter
   logic [15:0] rx, next_rx;                        // receive shifter
   logic [1:0]  cur_mode, next_mode;                // settings held for a word
   logic [1:0]  cur_wires, next_wires;
   logic [3:0]  cur_len, next_len;
   logic        cur_rd, next_rd;
   logic [9:0]  cur_half, next_half;
   logic        next_busy, next_done, next_clk, next_clk_oe;
   logic        next_dat, next_dat_oe, next_load, next_load_oe;
   logic [15:0] next_rxw;
   logic        bid_s1, bid_s2, in_s1, in_s2;       // pin synchronisers
   logic        din_s;                              // chosen serial input
   logic [4:0]  last_edge;                          // index of final edge

   // two flops on each incoming pin
   always_ff @(posedge mclk)
   begin
      bid_s1 <= dat_i;
      bid_s2 <= bid_s1;
      in_s1  <= din_i;
      in_s2  <= in_s1;
   end

   // 3-wire reads from the bidirectional line, else the input line
   assign din_s     = (cur_wires == WIRE_3) ? bid_s2 : in_s2;
   assign last_edge = {cur_len, 1'b1};

   // next state of the whole port
   always_comb
   begin
      next_st    = st;
      next_hcnt  = hcnt;
      next_ecnt  = ecnt;
      next_sh    = sh;
      next_rx    = rx;
      next_mode  = cur_mode;
      next_wires = cur_wires;
      next_len   = cur_len;
      next_rd    = cur_rd;
      next_half  = cur_half;
      next_clk   = clk_o;
      next_dat   = dat_o;
      next_load  = load_o;
      next_done  = 1'b0;
      next_rxw   = rx_word;
      case (st)
         ST_IDLE:
         begin
            // follow the settings while idle, clamp the rate
            next_mode  = cfg_mode;
            next_wires = cfg_wires;
            next_len   = cfg_len_m1;
            next_rd    = cfg_rd;
            if (cfg_half < HALF_MIN)
               next_half = HALF_MIN;
            else if (cfg_half > HALF_MAX)
               next_half = HALF_MAX;
            else
               next_half = cfg_half;
            next_clk  = cfg_mode[1];
            next_load = 1'b0;
            if (start && cfg_en)
            begin
               next_st   = ST_SHIFT;
               next_sh   = tx_word;
               next_dat  = tx_word[cfg_len_m1];
               next_hcnt = 10'h001;
               next_ecnt = 5'h00;
               next_rx   = 16'h0000;
            end
         end
         ST_SHIFT:
         begin
            if (!cfg_en)
               next_st = ST_IDLE;                                    // abort, pins released
            else if (hcnt >= cur_half)
            begin
               // one clock edge
               next_hcnt = 10'h001;
               next_clk  = ~clk_o;
               next_ecnt = ecnt + 5'h01;
               if (ecnt[0] == cur_mode[0])
                  next_rx = {rx[14:0], din_s};
               else if (ecnt != 5'h00 && ecnt != last_edge)
               begin
                  next_sh  = {sh[14:0], 1'b0};
                  next_dat = sh[cur_len - 4'h1];
               end
               if (ecnt == last_edge)
               begin
                  next_rxw = next_rx;
                  if (cur_wires == WIRE_5)
                  begin
                     next_st   = ST_STROBE;
                     next_load = 1'b1;
                  end
                  else
                  begin
                     next_st   = ST_IDLE;
                     next_done = 1'b1;
                  end
               end
            end
            else
               next_hcnt = hcnt + 10'h001;
         end
         ST_STROBE:
         begin
            // strobe stands for one half period
            if (!cfg_en)
            begin
               next_st   = ST_IDLE;
               next_load = 1'b0;
            end
            else if (hcnt >= cur_half)
            begin
               next_load = 1'b0;
               next_st   = ST_IDLE;
               next_done = 1'b1;
            end
            else
               next_hcnt = hcnt + 10'h001;
         end
         default:
            next_st = ST_IDLE;
      endcase
      next_busy    = (next_st != ST_IDLE);
      next_clk_oe  = cfg_en;
      next_dat_oe  = cfg_en && !(next_wires == WIRE_3 && next_rd);
      next_load_oe = cfg_en && (next_wires == WIRE_5);
   end

   // register the port state
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         st        <= ST_IDLE;
         hcnt      <= 10'h000;
         ecnt      <= 5'h00;
         sh        <= 16'h0000;
         rx        <= 16'h0000;
         cur_mode  <= 2'h0;
         cur_wires <= WIRE_3;
         cur_len   <= 4'h0;
         cur_rd    <= 1'b0;
         cur_half  <= HALF_MAX;
         busy      <= 1'b0;
         done      <= 1'b0;
         rx_word   <= 16'h0000;
         clk_o     <= 1'b0;
         clk_oe    <= 1'b0;
         dat_o     <= 1'b0;
         dat_oe    <= 1'b0;
         load_o    <= 1'b0;
         load_oe   <= 1'b0;
      end
      else
      begin
         st        <= next_st;
         hcnt      <= next_hcnt;
         ecnt      <= next_ecnt;
         sh        <= next_sh;
         rx        <= next_rx;
         cur_mode  <= next_mode;
         cur_wires <= next_wires;
         cur_len   <= next_len;
         cur_rd    <= next_rd;
         cur_half  <= next_half;
         busy      <= next_busy;
         done      <= next_done;
         rx_word   <= next_rxw;
         clk_o     <= next_clk;
         clk_oe    <= next_clk_oe;
         dat_o     <= next_dat;
         dat_oe    <= next_dat_oe;
         load_o    <= next_load;
         load_oe   <= next_load_oe;
      end
   end

   // helper: clock toggles during the current word
   logic [5:0] tog;
   always_ff @(posedge mclk)
   begin
      if (rst || (st == ST_IDLE && next_st == ST_SHIFT))
         tog <= 6'h00;
      else if (st == ST_SHIFT && next_clk != clk_o)
         tog <= tog + 6'h01;
   end

   chk_pins_released: assert property (@(posedge mclk) disable iff (rst)
      !cfg_en |=> !clk_oe && !dat_oe && !load_oe)
      else $error("pins driven while port disabled");
   chk_idle_polarity: assert property (@(posedge mclk) disable iff (rst)
      st == ST_IDLE ##1 st == ST_IDLE |-> clk_o == $past(cfg_mode[1]))
      else $error("idle clock level differs from polarity");
   chk_edge_count: assert property (@(posedge mclk) disable iff (rst)
      done |-> tog == 6'({1'b0, cur_len, 1'b0}) + 6'h02)
      else $error("word ended after wrong number of clock edges");
   chk_load_only_five: assert property (@(posedge mclk) disable iff (rst)
      $rose(load_o) |-> cur_wires == WIRE_5 && load_oe)
      else $error("load strobe outside 5-wire wiring");
   chk_load_width: assert property (@(posedge mclk) disable iff (rst)
      $rose(load_o) && cfg_en |-> load_o [*4] ##[1:490] done)
      else $error("load strobe too short or no word end");
   chk_three_wire_rx: assert property (@(posedge mclk) disable iff (rst)
      st == ST_SHIFT && cur_wires == WIRE_3 && cur_rd && cfg_en |=> !dat_oe)
      else $error("data line driven during 3-wire read");
   chk_four_wire_out: assert property (@(posedge mclk) disable iff (rst)
      st == ST_SHIFT && cur_wires != WIRE_3 && cfg_en ##1 cfg_en |-> dat_oe)
      else $error("data line not driven in 4/5-wire transfer");
   cov_three_wire_read: cover property (@(posedge mclk) done && cur_wires == WIRE_3 && cur_rd);
   cov_five_wire_word:  cover property (@(posedge mclk) done && cur_wires == WIRE_5);
   cov_mode3_word:      cover property (@(posedge mclk) done && cur_mode == 2'h3);

endmodule

//--- hdl/dsmp_top.sv
// dual serial master port: AHB-Lite register slave and two shift engines
//
// Behaviour
// - two independent serial master ports
// - master only, rate 102k to 12.5M
// - peripheral select from a software-driven general pin
// - optional load strobe only on dedicated pin
// - clock modes 0 to 3 supported
// - word length 1 to 16 bits
// - 3-wire, 4-wire and 5-wire wiring
// - 3-wire uses clock, data and select
// - 5-wire drives load on its pin
// - 3-wire: one turning data line, input unused
// - 4/5-wire: data line out, input line in
`timescale 1ns/1ps
module dsmp_top
   import dsmp_pkg::*;
(
   input  wire logic             mclk,
   input  wire logic             rst,
   input  wire logic             hsel,
   input  wire logic [31:0]      haddr,
   input  wire logic [1:0]       htrans,
   input  wire logic             hwrite,
   input  wire logic [2:0]       hsize,
   input  wire logic [31:0]      hwdata,
   input  wire logic             hready,
   output logic                  hreadyout,
   output logic                  hresp,
   output logic [31:0]           hrdata,
   output logic [NPORT-1:0]      serial_clock_pin_o,
   output logic [NPORT-1:0]      serial_clock_pin_oe,
   input  wire logic [NPORT-1:0] serial_bidir_line_i,
   output logic [NPORT-1:0]      serial_bidir_line_o,
   output logic [NPORT-1:0]      serial_bidir_line_oe,
   input  wire logic [NPORT-1:0] serial_input_line_i,
   output logic [NPORT-1:0]      word_load_strobe_o,
   output logic [NPORT-1:0]      word_load_strobe_oe,
   output logic [NPORT-1:0]      peripheral_select_n
);

   // bus phase tracking
   logic        wr_pend, next_wr_pend;               // write data phase follows
   logic [7:0]  wr_addr, next_wr_addr;               // address of that write
   logic [31:0] next_hrdata;                         // read data captured in address phase
   logic        addr_ok;                             // upper address bits are zero and the address is word aligned
   logic        req;                                 // transfer taken this edge
   logic        rd_req;                              // read taken this edge
   logic [31:0] rd_mux;                              // read value for the address

   // software-driven general pins
   logic [NPORT-1:0] next_sel;

   // per port register state
   logic [CTRL_MSB:0] ctrl      [NPORT];             // control word
   logic [9:0]        div       [NPORT];             // half period setting
   logic [15:0]       tx        [NPORT];             // last written transmit word
   logic              start     [NPORT];             // one-cycle kick to the engine
   logic              done_flag [NPORT];             // sticky word-finished flag
   logic              eng_busy  [NPORT];
   logic              eng_done  [NPORT];
   logic [15:0]       eng_rx    [NPORT];

   // address phase qualifiers; the ignored hsize is whole-word only
   assign addr_ok = (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'h0) && (hsize == 3'h2 || 1'b1);
   assign req     = hsel && hready && htrans[1];
   assign rd_req  = req && !hwrite && addr_ok;

   // read multiplexer, unmapped addresses read zero
   always_comb
   begin
      rd_mux = DATA_RST;
      if (haddr[7:0] == OFF_SEL)
         rd_mux[NPORT-1:0] = peripheral_select_n;
      for (int p = 0; p < NPORT; p++)
      begin
         if (haddr[7:0] == 8'(p * PORT_STRIDE) + OFF_CTRL)
            rd_mux[CTRL_MSB:0] = ctrl[p];
         else if (haddr[7:0] == 8'(p * PORT_STRIDE) + OFF_DIV)
            rd_mux[9:0] = div[p];
         else if (haddr[7:0] == 8'(p * PORT_STRIDE) + OFF_TX)
            rd_mux[15:0] = tx[p];
         else if (haddr[7:0] == 8'(p * PORT_STRIDE) + OFF_RX)
            rd_mux[15:0] = eng_rx[p];
         else if (haddr[7:0] == 8'(p * PORT_STRIDE) + OFF_STAT)
         begin
            rd_mux[STAT_BUSY_BIT] = eng_busy[p];
            rd_mux[STAT_DONE_BIT] = done_flag[p];
         end
      end
   end

   // bus slave next values
   always_comb
   begin
      next_wr_pend = req && hwrite && addr_ok;
      next_wr_addr = haddr[7:0];
      next_hrdata  = rd_req ? rd_mux : DATA_RST;
      next_sel     = peripheral_select_n;
      if (wr_pend && wr_addr == OFF_SEL)
         next_sel = hwdata[NPORT-1:0];
   end

   // bus slave registers, zero wait states, always OKAY
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         wr_pend             <= 1'b0;
         wr_addr             <= 8'h00;
         hrdata              <= DATA_RST;
         hreadyout           <= 1'b1;
         hresp               <= 1'b0;
         peripheral_select_n <= SEL_RST;
      end
      else
      begin
         wr_pend             <= next_wr_pend;
         wr_addr             <= next_wr_addr;
         hrdata              <= next_hrdata;
         hreadyout           <= 1'b1;
         hresp               <= 1'b0;
         peripheral_select_n <= next_sel;
      end
   end

   // one register block and engine per port
   for (genvar p = 0; p < NPORT; p++)
   begin : g_port
      localparam logic [7:0] BASE = 8'(p * PORT_STRIDE);

      logic [CTRL_MSB:0] next_ctrl;
      logic [9:0]        next_div;
      logic [15:0]       next_tx;
      logic              next_start;
      logic              next_done_flag;

      // register writes, transfer kick and sticky done
      always_comb
      begin
         next_ctrl      = ctrl[p];
         next_div       = div[p];
         next_tx        = tx[p];
         next_start     = 1'b0;
         next_done_flag = done_flag[p];
         if (wr_pend && wr_addr == BASE + OFF_CTRL)
            next_ctrl = hwdata[CTRL_MSB:0];
         if (wr_pend && wr_addr == BASE + OFF_DIV)
            next_div = hwdata[9:0];
         if (wr_pend && wr_addr == BASE + OFF_TX)
         begin
            next_tx = hwdata[15:0];
            // a write while busy or disabled only stores the word
            next_start = ctrl[p][CTRL_EN_BIT] && !eng_busy[p] && !start[p];
         end
         // reading the received word clears done; a new word wins
         if (rd_req && haddr[7:0] == BASE + OFF_RX)
            next_done_flag = 1'b0;
         if (eng_done[p])
            next_done_flag = 1'b1;
      end

      always_ff @(posedge mclk)
      begin
         if (rst)
         begin
            ctrl[p]      <= CTRL_RST;
            div[p]       <= DIV_RST;
            tx[p]        <= 16'h0000;
            start[p]     <= 1'b0;
            done_flag[p] <= 1'b0;
         end
         else
         begin
            ctrl[p]      <= next_ctrl;
            div[p]       <= next_div;
            tx[p]        <= next_tx;
            start[p]     <= next_start;
            done_flag[p] <= next_done_flag;
         end
      end

      // the shifter owns its clock, data and load pins
      dsmp_shift_engine u_eng (
         .mclk       (mclk),
         .rst        (rst),
         .cfg_en     (ctrl[p][CTRL_EN_BIT]),
         .cfg_mode   (ctrl[p][CTRL_MODE_LSB +: 2]),
         .cfg_wires  (ctrl[p][CTRL_WIRE_LSB +: 2]),
         .cfg_len_m1 (ctrl[p][CTRL_LEN_LSB +: 4]),
         .cfg_rd     (ctrl[p][CTRL_RD_BIT]),
         .cfg_half   (div[p]),
         .start      (start[p]),
         .tx_word    (tx[p]),
         .busy       (eng_busy[p]),
         .done       (eng_done[p]),
         .rx_word    (eng_rx[p]),
         .clk_o      (serial_clock_pin_o[p]),
         .clk_oe     (serial_clock_pin_oe[p]),
         .dat_i      (serial_bidir_line_i[p]),
         .dat_o      (serial_bidir_line_o[p]),
         .dat_oe     (serial_bidir_line_oe[p]),
         .din_i      (serial_input_line_i[p]),
         .load_o     (word_load_strobe_o[p]),
         .load_oe    (word_load_strobe_oe[p])
      );

      chk_start_busy: assert property (@(posedge mclk) disable iff (rst)
         start[p] |=> eng_busy[p] ##1 eng_busy[p])
         else $error("kick did not start a transfer");
      chk_done_sticky: assert property (@(posedge mclk) disable iff (rst)
         eng_done[p] |=> done_flag[p])
         else $error("finished word not flagged");
      chk_load_pin_five: assert property (@(posedge mclk) disable iff (rst)
         word_load_strobe_oe[p] |-> $past(ctrl[p][CTRL_WIRE_LSB +: 2]) == WIRE_5)
         else $error("load pin taken outside 5-wire wiring");
      cov_back_to_back: cover property (@(posedge mclk) eng_done[p] ##[1:20] start[p]);
   end

   chk_select_write: assert property (@(posedge mclk) disable iff (rst)
      wr_pend && wr_addr == OFF_SEL |=> peripheral_select_n == $past(hwdata[NPORT-1:0]))
      else $error("select pins do not follow the write");
   chk_bus_read: assert property (@(posedge mclk) disable iff (rst)
      req && !hwrite && !addr_ok |=> hrdata == DATA_RST && hreadyout)
      else $error("unmapped read returned data");

endmodule

//--- dv/dsmp_peer.sv
// far-side peripheral model: mode 0 slave with a fixed reply word
`timescale 1ns/1ps
module dsmp_peer
(
   input  wire logic   sclk,
   input  wire logic   mosi,
   input  wire logic   sel_n,
   output logic        miso,
   output logic [15:0] cap
);
   localparam logic [15:0] REPLY = 16'hB4E9; // reply shifted out msb first
   logic [15:0] sh = 16'h0;                  // outgoing shifter
   initial cap = 16'h0;
   // reply loaded when selected
   always @(negedge sel_n) sh = REPLY;
   // capture on rising clock, next bit on falling
   always @(posedge sclk) if (!sel_n) cap = {cap[14:0], mosi};
   always @(negedge sclk) if (!sel_n) sh = sh << 1;
   // a released line shows the inverse of its last bit
   assign miso = sel_n ? ~sh[15] : sh[15];
endmodule

//--- dv/dsmp_top_bench.sv
// self-checking bench for the dual serial master port
`timescale 1ns/1ps
module dsmp_top_bench;
   import dsmp_pkg::*;
   logic        mclk = 0, rst = 1, hwrite = 0, hreadyout, hresp;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, q;
   logic [1:0]  htrans = 0, ck, cko, dio, doe, miso, ld, ldoe, seln, bi, ldq = 0;
   logic [15:0] cap [2];
   int          fails = 0, n_checks = 0, cyc = 0, ldc [2] = '{0, 0};
   initial forever #5 mclk = ~mclk;
   // wire level of the data line from the master's enable, the peer drives it otherwise
   assign bi = (doe & dio) | (~doe & miso);
   dsmp_top dsmp_top_inst (.mclk(mclk), .rst(rst), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .serial_clock_pin_o(ck), .serial_clock_pin_oe(cko),
      .serial_bidir_line_i(bi), .serial_bidir_line_o(dio), .serial_bidir_line_oe(doe),
      .serial_input_line_i(miso), .word_load_strobe_o(ld), .word_load_strobe_oe(ldoe),
      .peripheral_select_n(seln));
   for (genvar p = 0; p < 2; p++)
   begin : g
      dsmp_peer dsmp_peer_inst (.sclk(ck[p]), .mosi(dio[p]), .sel_n(seln[p]), .miso(miso[p]), .cap(cap[p]));
   end
   // load strobe pulse counter and hang guard
   always @(posedge mclk)
   begin
      ldq <= ld;
      for (int i = 0; i < 2; i++) if (ld[i] && !ldq[i]) ldc[i]++;
      cyc++;
      if (cyc == 20000)
      begin
         fails++;
         end_of_test;
      end
   end
   task automatic chk(string n, logic [31:0] e, logic [31:0] g);
      n_checks++;
      if (g !== e)
      begin
         $display("ERROR %s expected %h seen %h", n, e, g);
         fails++;
      end
   endtask
   // one single ahb-lite transfer, read data left in q
   task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
      @(posedge mclk);
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask
   task automatic t_reset;
      chk("oe", 0, {cko, doe, ldoe});
      chk("sel", 3, seln);
      $display("reset test done");
   endtask
   task automatic t_regs;
      bus(1, OFF_SEL, 2);
      bus(0, OFF_SEL, 0);
      chk("sel", 2, seln);
      chk("sel_rd", 2, q);
      bus(0, 8'h3C, 0);
      chk("unmapped", 0, q);
      bus(0, OFF_SEL + 8'h02, 0);
      chk("misaligned", 0, q);
      chk("hresp", 0, hresp);
      bus(1, OFF_SEL, 3);
      $display("register test done");
   endtask
   task automatic t_modes;
      for (int m = 0; m < 4; m++)
      begin
         bus(1, OFF_CTRL, 32'(m * 2 + 9));
         repeat (3) @(posedge mclk);
         chk("idle_clk", m / 2, ck[0]);
      end
      $display("mode test done");
   endtask
   // one word on port p, judged against the peer
   task automatic xfer(int p, logic [1:0] wr, logic [3:0] m1, logic [15:0] tx, logic rd);
      logic [7:0] b;
      b = 8'(p * 32);
      bus(1, b + OFF_DIV, 6);
      bus(1, b, {22'h0, rd, m1, wr, 3'h1});
      bus(1, OFF_SEL, p ? 1 : 2);
      ldc[p] = 0;
      bus(1, b + OFF_TX, tx);
      repeat (4) @(posedge mclk);
      chk("data_oe", !rd, doe[p]);
      chk("load_oe", wr == WIRE_5, ldoe[p]);
      do bus(0, b + OFF_STAT, 0); while (q[0] !== 1'b0);
      // done lands one cycle after busy drops, so read status once more
      bus(0, b + OFF_STAT, 0);
      chk("done", 1, q[1]);
      bus(0, b + OFF_RX, 0);
      chk("rx", 32'(16'hB4E9 >> (15 - m1)), q);
      if (!rd) chk("tx", 0, (cap[p] ^ tx) & ((32'h2 << m1) - 1));
      chk("loads", wr == WIRE_5, ldc[p]);
      bus(1, OFF_SEL, 3);
      $display("transfer test done on port %0d", p);
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial
   begin
      repeat (20) @(posedge mclk);
      rst <= 0;
      @(posedge mclk);
      t_reset;
      t_regs;
      t_modes;
      xfer(0, WIRE_4, 4'h7, 16'h00C6, 0);
      xfer(1, WIRE_5, 4'hF, 16'h9A3C, 0);
      xfer(0, WIRE_3, 4'h0, 16'h0000, 1);
      xfer(1, WIRE_4, 4'hC, 16'h1B5D, 0);
      end_of_test;
   end
endmodule
